// *** shared/ptrc_consts.vh ***
// Register map and field constants of the per-port tag and rate-count bank.
// Assumes an 8-bit register space behind a 32-bit Avalon-MM word slave.
`ifndef PTRC_CONSTS_VH
`define PTRC_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PTRC_IDX_P1_VID_LO 8'h14
`define PTRC_IDX_P1_CTRL5 8'h15
`define PTRC_IDX_P2_VID_LO 8'h24
`define PTRC_IDX_P2_CTRL5 8'h25
`define PTRC_IDX_P3_VID_LO 8'h34
`define PTRC_IDX_P3_CTRL5 8'h35
`define PTRC_IDX_P1_VID_HI 8'h13
`define PTRC_IDX_P2_VID_HI 8'h23
`define PTRC_IDX_P3_VID_HI 8'h33
`define PTRC_IDX_W 8

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define PTRC_VID_LO_RST 8'h01
`define PTRC_VID_HI_RST 8'h00
`define PTRC_CTRL5_RST 8'h00
`define PTRC_B_MAC_MODE 7
`define PTRC_B_SAF1 6
`define PTRC_B_SAF2 5
`define PTRC_B_DROP_TAG 4
`define PTRC_F_LIM_HI 3
`define PTRC_F_LIM_LO 2
`define PTRC_B_GAP 1
`define PTRC_B_PRE 0
`define PTRC_P3_MASK 8'h9f
`define PTRC_LIM_ALL 2'h0
`define PTRC_LIM_BMF 2'h1
`define PTRC_LIM_BC 2'h3
`define PTRC_GAP_BYTES 5'h0c
`define PTRC_PRE_BYTES 5'h08
`define PTRC_RDLAT 1'b1
`define PTRC_STRAP_WAIT 2'h2
`define PTRC_STRAP_DONE 2'h3

`endif

// *** rtl/ptrc_port_cfg.v ***
// One port's classification logic driven by its tag and control bytes.
// Assumes frame descriptors arrive synchronous to clock_i.
`include "ptrc_consts.vh"

module ptrc_port_cfg (
  input wire [7:0] vid_lo_i,
  input wire [7:0] vid_hi_i,
  input wire [7:0] ctrl_i,
  input wire tagged_i,
  input wire [11:0] frm_vid_i,
  input wire is_bc_i,
  input wire is_mc_i,
  input wire is_flood_i,
  output wire [15:0] ins_tag_o,
  output wire [11:0] lookup_vid_o,
  output wire drop_o,
  output wire limit_count_o,
  output wire [4:0] extra_bytes_o
);
  reg lim_sel;

  // Default tag for untagged ingress and egress insertion
  assign ins_tag_o = {vid_hi_i, vid_lo_i};
  // Null VID falls back to the port default too
  assign lookup_vid_o = (!tagged_i || frm_vid_i == 12'h000) ?
    {vid_hi_i[3:0], vid_lo_i} : frm_vid_i;
  assign drop_o = tagged_i && ctrl_i[`PTRC_B_DROP_TAG];

  always @* begin
    case (ctrl_i[`PTRC_F_LIM_HI:`PTRC_F_LIM_LO])
      `PTRC_LIM_ALL: lim_sel = 1'b1;
      `PTRC_LIM_BMF: lim_sel = is_bc_i | is_mc_i | is_flood_i;
      `PTRC_LIM_BC: lim_sel = is_bc_i;
      default: lim_sel = 1'b1;
    endcase
  end
  assign limit_count_o = lim_sel;

  assign extra_bytes_o =
    (ctrl_i[`PTRC_B_GAP] ? `PTRC_GAP_BYTES : 5'h00) +
    (ctrl_i[`PTRC_B_PRE] ? `PTRC_PRE_BYTES : 5'h00);
endmodule

// *** rtl/ptrc_bank.v ***
// Three-port default tag and filter/rate-count control register bank.
// Assumes an Avalon-MM master on clock_i and a strap pin from outside.
`include "ptrc_consts.vh"

// Contract
// - Per-port default VID low byte, reset 01
// - High tag byte: priority, CFI, VID high
// - Default tag tags untagged frames, egress insertion
// - Untagged or null VID uses default VID
// - Port 3 bit 7: one MAC, zero PHY
// - Bit 7 reserved; port 1 bit gates clock
// - Bit 6 enables first address filter
// - Bit 5 enables second address filter
// - Bits 3:2 select counted frame kind
// - Bit 1 adds twelve gap bytes
// - Bit 0 adds eight preamble bytes
// - Copies per port at 14, 24, 34
module ptrc_bank (
  input wire clock_i,
  input wire sys_rst_i,
  input wire [9:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire port3_rx_valid_strap_pin_i,
  input wire [2:0] rx_tagged_i,
  input wire [35:0] rx_vid_i,
  input wire [2:0] rx_bc_i,
  input wire [2:0] rx_mc_i,
  input wire [2:0] rx_flood_i,
  output reg [47:0] ins_tag_o,
  output reg [35:0] lookup_vid_o,
  output reg [2:0] drop_o,
  output reg [2:0] limit_count_o,
  output reg [14:0] extra_bytes_o,
  output reg port3_mac_mode_o,
  output reg [1:0] saf1_en_o,
  output reg [1:0] saf2_en_o,
  output reg clk25_off_o
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [7:0] vid_lo_r [0:2];
  reg [7:0] vid_hi_r [0:2];
  reg [7:0] ctrl_r [0:2];
  reg strap_s1_r;
  reg strap_s2_r;
  reg [1:0] strap_cnt_r;
  reg pend_r;
  reg [31:0] rd_nxt;
  wire [47:0] tag_w;
  wire [35:0] lvid_w;
  wire [2:0] drop_w;
  wire [2:0] lim_w;
  wire [14:0] xb_w;
  wire [7:0] idx_w;
  wire acc_w;
  integer i;

  assign idx_w = avs_address_i[9:2];
  assign acc_w = avs_read_i | avs_write_i;

  // Port number 0..2 from the index high nibble, 3 when unmapped
  function [1:0] port_of;
    input [7:0] idx;
    begin
      case (idx)
        `PTRC_IDX_P1_VID_LO, `PTRC_IDX_P1_CTRL5,
        `PTRC_IDX_P1_VID_HI: port_of = 2'd0;
        `PTRC_IDX_P2_VID_LO, `PTRC_IDX_P2_CTRL5,
        `PTRC_IDX_P2_VID_HI: port_of = 2'd1;
        `PTRC_IDX_P3_VID_LO, `PTRC_IDX_P3_CTRL5,
        `PTRC_IDX_P3_VID_HI: port_of = 2'd2;
        default: port_of = 2'd3;
      endcase
    end
  endfunction

  // Register kind: 0 low VID, 1 control, 2 high tag byte
  function [1:0] kind_of;
    input [7:0] idx;
    begin
      case (idx[3:0])
        4'h4: kind_of = 2'd0;
        4'h5: kind_of = 2'd1;
        4'h3: kind_of = 2'd2;
        default: kind_of = 2'd3;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
    end else begin
      strap_s1_r <= port3_rx_valid_strap_pin_i;
      strap_s2_r <= strap_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (port_of(idx_w) != 2'd3) begin
      case (kind_of(idx_w))
        2'd0: rd_nxt[7:0] = vid_lo_r[port_of(idx_w)];
        2'd1: rd_nxt[7:0] = ctrl_r[port_of(idx_w)];
        2'd2: rd_nxt[7:0] = vid_hi_r[port_of(idx_w)];
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= 1'b1;
      if (acc_w && !pend_r) begin
        pend_r <= `PTRC_RDLAT;
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= avs_read_i ? rd_nxt : 32'h0000_0000;
      end else begin
        pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes, taken at the edge that samples waitrequest low
  // ----------------------------------------------------------------
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (i = 0; i < 3; i = i + 1) begin
        vid_lo_r[i] <= `PTRC_VID_LO_RST;
        vid_hi_r[i] <= `PTRC_VID_HI_RST;
        ctrl_r[i] <= `PTRC_CTRL5_RST;
      end
      strap_cnt_r <= 2'h0;
    end else begin
      // Wait until the synchroniser holds the pin, not its reset zero
      if (strap_cnt_r == `PTRC_STRAP_WAIT) begin
        ctrl_r[2][`PTRC_B_MAC_MODE] <= ~strap_s2_r;
      end
      if (strap_cnt_r != `PTRC_STRAP_DONE) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
      if (avs_write_i && pend_r && avs_byteenable_i[0] &&
          port_of(idx_w) != 2'd3) begin
        case (kind_of(idx_w))
          2'd0: vid_lo_r[port_of(idx_w)] <= avs_writedata_i[7:0];
          2'd2: vid_hi_r[port_of(idx_w)] <= avs_writedata_i[7:0];
          2'd1: begin
            // Port 3 has no filter bits; they stay zero
            if (port_of(idx_w) == 2'd2)
              ctrl_r[2] <= avs_writedata_i[7:0] & `PTRC_P3_MASK;
            else
              ctrl_r[port_of(idx_w)] <= avs_writedata_i[7:0];
          end
          default: vid_lo_r[0] <= vid_lo_r[0];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-port classification
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_port
      ptrc_port_cfg u_cfg (
        .vid_lo_i(vid_lo_r[g]),
        .vid_hi_i(vid_hi_r[g]),
        .ctrl_i(ctrl_r[g]),
        .tagged_i(rx_tagged_i[g]),
        .frm_vid_i(rx_vid_i[g*12 +: 12]),
        .is_bc_i(rx_bc_i[g]),
        .is_mc_i(rx_mc_i[g]),
        .is_flood_i(rx_flood_i[g]),
        .ins_tag_o(tag_w[g*16 +: 16]),
        .lookup_vid_o(lvid_w[g*12 +: 12]),
        .drop_o(drop_w[g]),
        .limit_count_o(lim_w[g]),
        .extra_bytes_o(xb_w[g*5 +: 5])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered outputs, one cycle after the frame inputs
  // ----------------------------------------------------------------
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ins_tag_o <= 48'h0;
      lookup_vid_o <= 36'h0;
      drop_o <= 3'h0;
      limit_count_o <= 3'h0;
      extra_bytes_o <= 15'h0;
      port3_mac_mode_o <= 1'b0;
      saf1_en_o <= 2'h0;
      saf2_en_o <= 2'h0;
      clk25_off_o <= 1'b0;
    end else begin
      ins_tag_o <= tag_w;
      lookup_vid_o <= lvid_w;
      drop_o <= drop_w;
      limit_count_o <= lim_w;
      extra_bytes_o <= xb_w;
      port3_mac_mode_o <= ctrl_r[2][`PTRC_B_MAC_MODE];
      saf1_en_o <= {ctrl_r[1][`PTRC_B_SAF1],
                    ctrl_r[0][`PTRC_B_SAF1]};
      saf2_en_o <= {ctrl_r[1][`PTRC_B_SAF2],
                    ctrl_r[0][`PTRC_B_SAF2]};
      clk25_off_o <= ctrl_r[0][`PTRC_B_MAC_MODE];
    end
  end
endmodule

// *** tb/ptrc_bank_properties.sv ***
// Concurrent checks on the ports of the tag and rate-count bank.
// Assumes one clock domain and bus requests held until answered.
module ptrc_chk (
  input wire clock_i,
  input wire sys_rst_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire [2:0] rx_tagged_i,
  input wire [35:0] rx_vid_i,
  input wire [2:0] rx_bc_i,
  input wire [35:0] lookup_vid_o,
  input wire [2:0] drop_o,
  input wire [2:0] limit_count_o,
  input wire [14:0] extra_bytes_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_ask;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ans;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_answer_one_wait: assert property (s_ask |=> s_ans)
    else $error("bus answer late or held too long");
  a_idle_no_answer: assert property (
    !(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer without request");
  a_rdata_hold: assert property (
    avs_waitrequest_o |-> $stable(avs_readdata_o))
    else $error("read data moved between answers");
  a_upper_zero: assert property (
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_drop_untagged: assert property (
    (drop_o & ~$past(rx_tagged_i)) == 3'h0)
    else $error("untagged frame dropped");
  a_bc_counted: assert property (
    (limit_count_o & $past(rx_bc_i)) == $past(rx_bc_i))
    else $error("broadcast frame not counted");
  a_lookup_frame: assert property (
    $past(rx_tagged_i[0]) && $past(rx_vid_i[11:0]) != 12'h0
    |-> lookup_vid_o[11:0] == $past(rx_vid_i[11:0]))
    else $error("tagged frame lost its own vid");
  a_extra_sum: assert property (
    extra_bytes_o[4:0] inside {5'h00, 5'h08, 5'h0c, 5'h14})
    else $error("extra byte count not a gap/preamble sum");
endmodule

bind ptrc_bank ptrc_chk u_chk (.clock_i, .sys_rst_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .rx_tagged_i,
  .rx_vid_i, .rx_bc_i, .lookup_vid_o, .drop_o, .limit_count_o,
  .extra_bytes_o);

// *** tb/tb.sv ***
// Self-checking bench of the tag and rate-count bank.
// Assumes the bank answers each bus request after one wait cycle.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 0;
  logic sys_rst_i = 1;
  logic avs_read_i = 0;
  logic avs_write_i = 0;
  logic [9:0] avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0;
  logic [3:0] avs_byteenable_i = 0;
  logic [2:0] tg = 0, bc = 0, fl = 0, mc = 0;
  logic strap = 0;
  logic [35:0] vid = 0;
  wire [31:0] rdata;
  wire wreq, mac, ck;
  wire [47:0] ins;
  wire [35:0] lkp;
  wire [2:0] drop, lim;
  wire [14:0] xb;
  wire [1:0] s1, s2;
  int fails = 0, compares = 0, cyc = 0;
  ptrc_bank DUT (.clock_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .port3_rx_valid_strap_pin_i(strap), .rx_tagged_i(tg), .rx_vid_i(vid),
    .rx_bc_i(bc), .rx_mc_i(mc), .rx_flood_i(fl), .ins_tag_o(ins),
    .lookup_vid_o(lkp), .drop_o(drop), .limit_count_o(lim),
    .extra_bytes_o(xb), .port3_mac_mode_o(mac), .saf1_en_o(s1),
    .saf2_en_o(s2), .clk25_off_o(ck));
  initial forever #4 clock_i = ~clock_i;
  task summarize;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs about 110 cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      summarize;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Request held until waitrequest is seen low at an edge
  task acc(input bit w, input [7:0] i, input [7:0] d, input [3:0] be);
    @(posedge clock_i);
    avs_address_i <= {i, 2'b00};
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clock_i); while (wreq !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task rd(input [7:0] i, input [7:0] e);
    acc(0, i, 8'h0, 4'h0);
    `CHK(rdata, {24'h0, e})
  endtask
  initial begin
    tick(3);
    sys_rst_i <= 0;
    tick(4);
    rd(8'h14, 8'h01);
    rd(8'h24, 8'h01);
    rd(8'h34, 8'h01);
    rd(8'h13, 8'h00);
    rd(8'h25, 8'h00);
    rd(8'h35, 8'h80);
    `CHK(mac, 1'b1)
    acc(1, 8'h35, 8'hff, 4'h1);
    rd(8'h35, 8'h9f);
    acc(1, 8'h35, 8'h00, 4'h1);
    acc(1, 8'h15, 8'h83, 4'h1);
    acc(1, 8'h25, 8'h62, 4'h1);
    acc(1, 8'h10, 8'h55, 4'h1);
    acc(1, 8'h14, 8'h77, 4'h0);
    rd(8'h15, 8'h83);
    rd(8'h10, 8'h00);
    rd(8'h14, 8'h01);
    `CHK({mac, ck}, 2'b01)
    `CHK(xb[4:0], 5'h14)
    `CHK({s1, s2}, 4'ha)
    `CHK(xb[9:5], 5'h0c)
    acc(1, 8'h14, 8'h5a, 4'h1);
    acc(1, 8'h13, 8'ha3, 4'h1);
    tick(2);
    `CHK(ins[15:0], 16'ha35a)
    `CHK(lkp[11:0], 12'h35a)
    tg <= 3'h1;
    tick(2);
    `CHK(lkp[11:0], 12'h35a)
    vid[11:0] <= 12'h7e5;
    fl <= 3'h1;
    for (int m = 0; m < 4; m++) begin
      acc(1, 8'h15, {4'h1, m[1:0], 2'b01}, 4'h1);
      tick(2);
      `CHK({drop[0], xb[4:0], lim[0]}, {6'h28, m != 3})
    end
    `CHK(lkp[11:0], 12'h7e5)
    fl <= 3'h0;
    mc <= 3'h1;
    acc(1, 8'h15, 8'h04, 4'h1);
    tick(2);
    `CHK(lim[0], 1'b1)
    acc(1, 8'h15, 8'h0c, 4'h1);
    tick(2);
    `CHK(lim[0], 1'b0)
    mc <= 3'h0;
    bc <= 3'h1;
    tick(2);
    `CHK(lim[0], 1'b1)
    tg <= 3'h0;
    bc <= 3'h0;
    strap <= 1'b1;
    tick(1);
    sys_rst_i <= 1;
    tick(2);
    sys_rst_i <= 0;
    tick(4);
    rd(8'h15, 8'h00);
    rd(8'h35, 8'h00);
    `CHK(mac, 1'b0)
    summarize;
  end
endmodule
